// *** hw/irq_ctrl.sv ***
// Summary of operation
// - Captured second-level bits cleared after read strobe
// - New event after read reasserts unmasked interrupt
// - Uncaptured bits survive the read
// - First level sets on group OR rising edge
// - Masks never affect second-level event set or clear
// - Unmasking a pending event asserts interrupt
// - Interrupt needs both mask levels clear
// - Active level sources re-set after clear
// - GPIO group unmasked, prevention bits 5:4
// - External events set only after stable debounce
// - Power button falling edge, 10 ms, bit D0
// - Converter group: round robin, touch, coulomb
// - Charger overvoltage, temperature, completion events
// - Charger USB, battery, current limit, overvoltage
// - Clock group update, alarm, summary OR
// - Regulator group heat, overcurrent, failure
// - Accessory presses and plug changes debounced
// - Unmasked latched event drives interrupt high
// - First-level read clears captured bits only
// - Mask bit one masks; host reads tree
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Synchroniser with optional debounce and edge detect
// ****************************************
module event_detect
   import irq_ctrl_pkg::*;
#(
   parameter detect_e   MODE   = DET_LEVEL,
   parameter logic [DB_W-1:0] CYCLES = 24'd1,
   parameter logic            IDLE   = 1'b0
) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic src,
   output logic      hit
);
   logic [2:0]      sync;
   logic            stable;
   logic            prev;
   logic [DB_W-1:0] cnt;

   wire agree    = sync[1] == sync[2];
   wire differs  = sync[2] != stable;
   wire settled  = agree && differs && (cnt >= CYCLES - 24'd1);
   wire rise     = settled && sync[2];
   wire fall     = settled && !sync[2];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync   <= {3{IDLE}};
         stable <= IDLE;
         prev   <= IDLE;
         cnt    <= '0;
      end else begin
         sync   <= {sync[1:0], src};
         prev   <= stable;
         if (settled) begin
            stable <= sync[2];
         end
         if (!agree || !differs || settled) begin
            cnt <= '0;
         end else begin
            cnt <= cnt + 24'd1;
         end
      end
   end

   always_comb begin
      unique case (MODE)
         DET_LEVEL: hit = stable;
         DET_RISE:  hit = stable && !prev;
         DET_FALL:  hit = !stable && prev;
         DET_BOTH:  hit = stable != prev;
      endcase
   end
endmodule

// ****************************************
// Interrupt controller top
// ****************************************
module irq_ctrl
   import irq_ctrl_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       reg_rd,
   input  wire logic       reg_wr,
   input  wire logic [9:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   input  wire logic       power_button_n,
   input  wire logic       round_robin_done,
   input  wire logic       touch_wake,
   input  wire logic       coulomb_overflow,
   input  wire logic       battery_overvoltage,
   input  wire logic       battery_temp_fault,
   input  wire logic       charge_complete,
   input  wire logic       usb_attach_change,
   input  wire logic       battery_presence_change,
   input  wire logic       input_current_limit,
   input  wire logic       input_overvoltage,
   input  wire logic       clock_update_flag,
   input  wire logic       alarm_match_flag,
   input  wire logic       update_irq_enable,
   input  wire logic       alarm_irq_enable,
   input  wire logic [7:0] gpio_pin_event,
   input  wire logic       die_heat_warning,
   input  wire logic       battery_overcurrent,
   input  wire logic       regulator_failure,
   input  wire logic       long_press_event,
   input  wire logic       short_press_event,
   input  wire logic       headphone_plug_change,
   input  wire logic       headset_plug_change,
   output logic            irq_out_pin
);
   // ****************************************
   // Register bus request
   // ****************************************
   reg_req_s req;
   assign req = '{rd: reg_rd, wr: reg_wr, addr: reg_addr, wdata: reg_wdata};

   // ****************************************
   // Event sources
   // ****************************************
   logic [7:0] conv_hit;
   logic [7:0] chg_hit;
   logic [7:0] clk_hit;
   logic [7:0] gpio_hit;
   logic [7:0] vr_hit;
   logic [7:0] acc_hit;
   logic       pwr_hit;

   event_detect #(.MODE(DET_FALL), .CYCLES(DB_W'(CYC_10MS)), .IDLE(1'b1)) u_pwr (
      .clk(clk), .rst_n(rst_n), .src(power_button_n), .hit(pwr_hit));

   event_detect #(.MODE(DET_LEVEL)) u_rnd (
      .clk(clk), .rst_n(rst_n), .src(round_robin_done), .hit(conv_hit[0]));
   event_detect #(.MODE(DET_RISE)) u_touch (
      .clk(clk), .rst_n(rst_n), .src(touch_wake), .hit(conv_hit[1]));
   event_detect #(.MODE(DET_LEVEL)) u_coul (
      .clk(clk), .rst_n(rst_n), .src(coulomb_overflow), .hit(conv_hit[2]));
   assign conv_hit[7:3] = 5'h00;

   assign chg_hit[0] = 1'b0;
   event_detect #(.MODE(DET_BOTH)) u_bovp (
      .clk(clk), .rst_n(rst_n), .src(battery_overvoltage), .hit(chg_hit[1]));
   event_detect #(.MODE(DET_LEVEL), .CYCLES(DB_W'(CYC_1MS))) u_temp (
      .clk(clk), .rst_n(rst_n), .src(battery_temp_fault), .hit(chg_hit[2]));
   event_detect #(.MODE(DET_RISE), .CYCLES(DB_W'(CYC_1MS))) u_comp (
      .clk(clk), .rst_n(rst_n), .src(charge_complete), .hit(chg_hit[3]));
   event_detect #(.MODE(DET_BOTH), .CYCLES(DB_W'(CYC_10MS))) u_usb (
      .clk(clk), .rst_n(rst_n), .src(usb_attach_change), .hit(chg_hit[4]));
   event_detect #(.MODE(DET_LEVEL), .CYCLES(DB_W'(CYC_500MS))) u_bat (
      .clk(clk), .rst_n(rst_n), .src(battery_presence_change), .hit(chg_hit[5]));
   event_detect #(.MODE(DET_LEVEL), .CYCLES(DB_W'(CYC_32MS))) u_ilim (
      .clk(clk), .rst_n(rst_n), .src(input_current_limit), .hit(chg_hit[6]));
   event_detect #(.MODE(DET_LEVEL), .CYCLES(DB_W'(CYC_10MS))) u_iovp (
      .clk(clk), .rst_n(rst_n), .src(input_overvoltage), .hit(chg_hit[7]));

   logic clk_upd;
   logic clk_alm;
   event_detect #(.MODE(DET_LEVEL)) u_upd (
      .clk(clk), .rst_n(rst_n), .src(clock_update_flag), .hit(clk_upd));
   event_detect #(.MODE(DET_LEVEL)) u_alm (
      .clk(clk), .rst_n(rst_n), .src(alarm_match_flag), .hit(clk_alm));
   logic en_upd;
   logic en_alm;
   event_detect #(.MODE(DET_LEVEL)) u_uen (
      .clk(clk), .rst_n(rst_n), .src(update_irq_enable), .hit(en_upd));
   event_detect #(.MODE(DET_LEVEL)) u_aen (
      .clk(clk), .rst_n(rst_n), .src(alarm_irq_enable), .hit(en_alm));
   wire clock_irq_summary = (clk_upd & en_upd) | (clk_alm & en_alm);
   always_comb begin
      clk_hit             = 8'h00;
      clk_hit[CLK_UPDATE] = clk_upd;
      clk_hit[CLK_ALARM]  = clk_alm;
      clk_hit[CLK_SUM]    = clock_irq_summary;
   end

   // GPIO inputs are already debounced and prevention-filtered upstream
   for (genvar g = 0; g < 8; g++) begin : g_gpio
      event_detect #(.MODE(DET_RISE)) u_gp (
         .clk(clk), .rst_n(rst_n), .src(gpio_pin_event[g]), .hit(gpio_hit[g]));
   end

   event_detect #(.MODE(DET_LEVEL), .CYCLES(DB_W'(CYC_10MS))) u_heat (
      .clk(clk), .rst_n(rst_n), .src(die_heat_warning), .hit(vr_hit[0]));
   event_detect #(.MODE(DET_LEVEL)) u_bocp (
      .clk(clk), .rst_n(rst_n), .src(battery_overcurrent), .hit(vr_hit[1]));
   event_detect #(.MODE(DET_LEVEL)) u_vrf (
      .clk(clk), .rst_n(rst_n), .src(regulator_failure), .hit(vr_hit[2]));
   assign vr_hit[7:3] = 5'h00;

   event_detect #(.MODE(DET_RISE), .CYCLES(DB_W'(CYC_80MS))) u_lp (
      .clk(clk), .rst_n(rst_n), .src(long_press_event), .hit(acc_hit[0]));
   event_detect #(.MODE(DET_RISE), .CYCLES(DB_W'(CYC_80MS))) u_sp (
      .clk(clk), .rst_n(rst_n), .src(short_press_event), .hit(acc_hit[1]));
   event_detect #(.MODE(DET_BOTH), .CYCLES(DB_W'(CYC_30MS))) u_hp (
      .clk(clk), .rst_n(rst_n), .src(headphone_plug_change), .hit(acc_hit[2]));
   event_detect #(.MODE(DET_BOTH), .CYCLES(DB_W'(CYC_30MS))) u_hs (
      .clk(clk), .rst_n(rst_n), .src(headset_plug_change), .hit(acc_hit[3]));
   assign acc_hit[7:4] = 4'h0;

   // ****************************************
   // Decode and read capture
   // ****************************************
   wire rd_top  = req.rd && req.addr == OFS_TOP_STATUS;
   wire rd_clk  = req.rd && req.addr == OFS_CLOCK_FLAGS;
   wire rd_vr   = req.rd && req.addr == OFS_VR_EVENTS;
   wire rd_conv = req.rd && req.addr == OFS_CONV_EVENTS;
   wire rd_chg  = req.rd && req.addr == OFS_CHG_EVENTS;
   wire rd_gpio = req.rd && req.addr == OFS_GPIO_EVENTS;
   wire rd_acc  = req.rd && req.addr == OFS_ACC_EVENTS;

   logic [7:0] top_ev;
   logic [7:0] top_mask;
   logic [7:0] clk_ev;
   logic [7:0] vr_ev;
   logic [7:0] vr_mask;
   logic [7:0] conv_ev;
   logic [7:0] conv_mask;
   logic [7:0] chg_ev;
   logic [7:0] chg_mask;
   logic [7:0] gpio_ev;
   logic [7:0] acc_ev;
   logic [7:0] acc_mask;

   // Self-clear pulse: one cycle after the strobe, clears only captured bits
   logic [7:0] cap_top;
   logic [7:0] cap_clk;
   logic [7:0] cap_vr;
   logic [7:0] cap_conv;
   logic [7:0] cap_chg;
   logic [7:0] cap_gpio;
   logic [7:0] cap_acc;

   // ****************************************
   // Second-level latches and group OR
   // ****************************************
   // Level bits yield to the clear for one cycle, then re-set
   wire [7:0] next_clk_ev  = (clk_ev  & ~cap_clk)  | (clk_hit & ~(cap_clk & LVL_CLK));
   wire [7:0] next_vr_ev   = (vr_ev   & ~cap_vr)   | (vr_hit & ~(cap_vr & LVL_VR));
   wire [7:0] next_conv_ev = (conv_ev & ~cap_conv) | (conv_hit & ~(cap_conv & LVL_CONV));
   wire [7:0] next_chg_ev  = (chg_ev  & ~cap_chg)  | (chg_hit & ~(cap_chg & LVL_CHG));
   wire [7:0] next_gpio_ev = (gpio_ev & ~cap_gpio) | gpio_hit;
   wire [7:0] next_acc_ev  = (acc_ev  & ~cap_acc)  | acc_hit;

   // Group OR uses unmasked second-level bits; power button bit takes the detector hit directly
   wire [7:0] grp_or;
   assign grp_or[TOP_POWER_BUTTON_EVENT] = pwr_hit;
   assign grp_or[TOP_CONV]   = |(conv_ev & ~conv_mask);
   assign grp_or[TOP_CHG]    = |(chg_ev  & ~chg_mask);
   assign grp_or[TOP_CLOCK]  = clk_ev[CLK_SUM];
   assign grp_or[TOP_GPIO]   = |gpio_ev;
   assign grp_or[TOP_VR]     = |(vr_ev   & ~vr_mask);
   assign grp_or[TOP_ACC]    = |(acc_ev  & ~acc_mask);
   assign grp_or[7]          = 1'b0;

   logic [7:0] grp_prev;
   wire  [7:0] grp_rise    = grp_or & ~grp_prev;
   wire  [7:0] next_top_ev = ((top_ev & ~cap_top) | grp_rise) & IMPL_TOP;
   wire        next_irq    = |(top_ev & ~top_mask & IMPL_TOP);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cap_top  <= 8'h00;
         cap_clk  <= 8'h00;
         cap_vr   <= 8'h00;
         cap_conv <= 8'h00;
         cap_chg  <= 8'h00;
         cap_gpio <= 8'h00;
         cap_acc  <= 8'h00;
      end else begin
         cap_top  <= rd_top  ? top_ev  : 8'h00;
         cap_clk  <= rd_clk  ? clk_ev  : 8'h00;
         cap_vr   <= rd_vr   ? vr_ev   : 8'h00;
         cap_conv <= rd_conv ? conv_ev : 8'h00;
         cap_chg  <= rd_chg  ? chg_ev  : 8'h00;
         cap_gpio <= rd_gpio ? gpio_ev : 8'h00;
         cap_acc  <= rd_acc  ? acc_ev  : 8'h00;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         clk_ev   <= 8'h00;
         vr_ev    <= 8'h00;
         conv_ev  <= 8'h00;
         chg_ev   <= 8'h00;
         gpio_ev  <= 8'h00;
         acc_ev   <= 8'h00;
         top_ev   <= 8'h00;
         grp_prev <= 8'h00;
      end else begin
         clk_ev   <= next_clk_ev;
         vr_ev    <= next_vr_ev & IMPL_VR;
         conv_ev  <= next_conv_ev & IMPL_CONV;
         chg_ev   <= next_chg_ev & IMPL_CHG;
         gpio_ev  <= next_gpio_ev;
         acc_ev   <= next_acc_ev & IMPL_ACC;
         top_ev   <= next_top_ev;
         grp_prev <= grp_or;
      end
   end

   // ****************************************
   // Mask registers
   // ****************************************
   wire wr_top_mask  = req.wr && req.addr == OFS_TOP_MASK;
   wire wr_vr_mask   = req.wr && req.addr == OFS_VR_MASK;
   wire wr_conv_mask = req.wr && req.addr == OFS_CONV_MASK;
   wire wr_chg_mask  = req.wr && req.addr == OFS_CHG_MASK;
   wire wr_acc_mask  = req.wr && req.addr == OFS_ACC_MASK;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         top_mask  <= RST_TOP_MASK;
         vr_mask   <= RST_VR_MASK;
         conv_mask <= RST_CONV_MASK;
         chg_mask  <= RST_CHG_MASK;
         acc_mask  <= RST_ACC_MASK;
      end else begin
         if (wr_top_mask)  top_mask  <= req.wdata;
         if (wr_vr_mask)   vr_mask   <= req.wdata & IMPL_VR;
         if (wr_conv_mask) conv_mask <= req.wdata & IMPL_CONV;
         if (wr_chg_mask)  chg_mask  <= req.wdata & IMPL_CHG;
         if (wr_acc_mask)  acc_mask  <= req.wdata & IMPL_ACC;
      end
   end

   // ****************************************
   // Read data and interrupt output
   // ****************************************
   logic [7:0] rd_mux;
   always_comb begin
      unique case (req.addr)
         OFS_TOP_STATUS:  rd_mux = top_ev;
         OFS_TOP_MASK:    rd_mux = top_mask;
         OFS_CLOCK_FLAGS: rd_mux = clk_ev;
         OFS_VR_EVENTS:   rd_mux = vr_ev;
         OFS_VR_MASK:     rd_mux = vr_mask;
         OFS_CONV_EVENTS: rd_mux = conv_ev;
         OFS_CONV_MASK:   rd_mux = conv_mask;
         OFS_CHG_EVENTS:  rd_mux = chg_ev;
         OFS_CHG_MASK:    rd_mux = chg_mask;
         OFS_GPIO_EVENTS: rd_mux = gpio_ev;
         OFS_ACC_EVENTS:  rd_mux = acc_ev;
         OFS_ACC_MASK:    rd_mux = acc_mask;
         default:         rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata   <= 8'h00;
         irq_out_pin <= 1'b0;
      end else begin
         if (req.rd) reg_rdata <= rd_mux;
         irq_out_pin <= next_irq;
      end
   end
endmodule

`default_nettype wire

// *** hw/irq_ctrl_pkg.sv ***
package irq_ctrl_pkg;

   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [9:0] OFS_TOP_STATUS   = 10'h004;
   localparam logic [9:0] OFS_TOP_MASK     = 10'h005;
   localparam logic [9:0] OFS_CLOCK_FLAGS  = 10'h01c;
   localparam logic [9:0] OFS_VR_EVENTS    = 10'h030;
   localparam logic [9:0] OFS_VR_MASK      = 10'h031;
   localparam logic [9:0] OFS_CONV_EVENTS  = 10'h05f;
   localparam logic [9:0] OFS_CONV_MASK    = 10'h060;
   localparam logic [9:0] OFS_CHG_EVENTS   = 10'h0d0;
   localparam logic [9:0] OFS_CHG_MASK     = 10'h0d1;
   localparam logic [9:0] OFS_GPIO_EVENTS  = 10'h0e8;
   localparam logic [9:0] OFS_ACC_EVENTS   = 10'h197;
   localparam logic [9:0] OFS_ACC_MASK     = 10'h198;

   // ****************************************
   // Reset values and implemented bits
   // ****************************************
   localparam logic [7:0] RST_TOP_MASK  = 8'hfa;
   localparam logic [7:0] RST_VR_MASK   = 8'h03;
   localparam logic [7:0] RST_CONV_MASK = 8'h00;
   localparam logic [7:0] RST_CHG_MASK  = 8'h00;
   localparam logic [7:0] RST_ACC_MASK  = 8'h0f;
   localparam logic [7:0] IMPL_TOP  = 8'h7f;
   localparam logic [7:0] IMPL_VR   = 8'h07;
   localparam logic [7:0] IMPL_CONV = 8'h07;
   localparam logic [7:0] IMPL_CHG  = 8'hfe;
   localparam logic [7:0] IMPL_ACC  = 8'h0f;
   localparam logic [7:0] LVL_CONV = 8'h05;
   localparam logic [7:0] LVL_CHG  = 8'he4;
   localparam logic [7:0] LVL_CLK  = 8'hb0;
   localparam logic [7:0] LVL_VR   = 8'h07;

   // ****************************************
   // First-level and clock flag bit positions
   // ****************************************
   localparam int TOP_POWER_BUTTON_EVENT = 0;
   localparam int TOP_CONV   = 1;
   localparam int TOP_CHG    = 2;
   localparam int TOP_CLOCK  = 3;
   localparam int TOP_GPIO   = 4;
   localparam int TOP_VR     = 5;
   localparam int TOP_ACC    = 6;
   localparam int CLK_UPDATE = 4;
   localparam int CLK_ALARM  = 5;
   localparam int CLK_SUM    = 7;

   // ****************************************
   // Debounce timing
   // ****************************************
   localparam int CLK_HZ        = 20_000_000;
   localparam int DB_10MS_US    = 10_000;
   localparam int DB_1MS_US     = 1_000;
   localparam int DB_500MS_US   = 500_000;
   localparam int DB_32MS_US    = 32_000;
   localparam int DB_80MS_US    = 80_000;
   localparam int DB_30MS_US    = 30_000;
   localparam int CYC_10MS  = DB_10MS_US * (CLK_HZ / 1_000_000);
   localparam int CYC_1MS   = DB_1MS_US * (CLK_HZ / 1_000_000);
   localparam int CYC_500MS = DB_500MS_US * (CLK_HZ / 1_000_000);
   localparam int CYC_32MS  = DB_32MS_US * (CLK_HZ / 1_000_000);
   localparam int CYC_80MS  = DB_80MS_US * (CLK_HZ / 1_000_000);
   localparam int CYC_30MS  = DB_30MS_US * (CLK_HZ / 1_000_000);
   localparam int DB_W      = 24;

   // ****************************************
   // Edge-detection modes
   // ****************************************
   typedef enum logic [1:0] {
      DET_LEVEL,
      DET_RISE,
      DET_FALL,
      DET_BOTH
   } detect_e;

   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [9:0] addr;
      logic [7:0] wdata;
   } reg_req_s;

endpackage

// *** dv/irq_ctrl_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Port checks for the interrupt controller
// ****************************************
module irq_ctrl_checker
   import irq_ctrl_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       reg_rd,
   input  wire logic       reg_wr,
   input  wire logic [9:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic [7:0] reg_rdata,
   input  wire logic [7:0] gpio_pin_event,
   input  wire logic       irq_out_pin
);
   logic [7:0] top_mask_sh;
   logic [7:0] gpio_prev;
   logic [3:0] gpio_quiet;
   logic       mapped;
   logic       rd_gpio;
   assign mapped = reg_addr inside {OFS_TOP_STATUS, OFS_TOP_MASK, OFS_CLOCK_FLAGS, OFS_VR_EVENTS,
      OFS_VR_MASK, OFS_CONV_EVENTS, OFS_CONV_MASK, OFS_CHG_EVENTS, OFS_CHG_MASK, OFS_GPIO_EVENTS,
      OFS_ACC_EVENTS, OFS_ACC_MASK};
   assign rd_gpio = reg_rd && reg_addr == OFS_GPIO_EVENTS;
   // Shadow of the top mask and a count of quiet cycles on the GPIO events
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         top_mask_sh <= RST_TOP_MASK;
         gpio_prev   <= 8'h00;
         gpio_quiet  <= 4'h0;
      end else begin
         if (reg_wr && reg_addr == OFS_TOP_MASK)
            top_mask_sh <= reg_wdata;
         gpio_prev  <= gpio_pin_event;
         gpio_quiet <= (gpio_pin_event != gpio_prev) ? 4'h0 : gpio_quiet + {3'h0, gpio_quiet != 4'hf};
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   unmapped_zero_a: assert property (reg_rd && !mapped |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   top_bit7_a: assert property (reg_rd && reg_addr == OFS_TOP_STATUS |=> !reg_rdata[7])
      else $error("top status bit 7 set");
   mask_readback_a: assert property (reg_wr && reg_addr == OFS_VR_MASK ##2 reg_rd && reg_addr == OFS_VR_MASK
      |=> reg_rdata == ($past(reg_wdata, 3) & IMPL_VR)) else $error("mask read back wrong");
   rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data moved without read");
   top_mask_read_a: assert property (reg_rd && reg_addr == OFS_TOP_MASK |=> reg_rdata == top_mask_sh)
      else $error("top mask read wrong");
   irq_masked_a: assert property (irq_out_pin |-> (~$past(top_mask_sh) & IMPL_TOP) != 8'h00)
      else $error("interrupt with all groups masked");
   irq_holds_a: assert property (irq_out_pin && !reg_rd && !reg_wr && !$past(reg_rd) && !$past(reg_wr)
      && !$past(reg_rd, 2) && !$past(reg_wr, 2) |=> irq_out_pin) else $error("interrupt dropped alone");
   gpio_clear_a: assert property (rd_gpio && gpio_quiet >= 4'ha ##2 rd_gpio && gpio_quiet >= 4'hc
      |=> reg_rdata == 8'h00) else $error("gpio events not cleared by read");
   cover property (reg_rd && reg_addr == OFS_TOP_STATUS ##1 reg_rdata != 8'h00);
   cover property ($rose(irq_out_pin));
   cover property ($fell(irq_out_pin));
endmodule
`default_nettype wire

// *** dv/host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Host controller register port model
// ****************************************
module host_model
   import irq_ctrl_pkg::*;
(
   input  wire logic       clk,
   input  wire logic [7:0] reg_rdata,
   output var  reg_req_s   req
);
   initial req = '{rd: 1'b0, wr: 1'b0, addr: 10'h3ff, wdata: 8'h00};
   // One strobe cycle per access, idle bus shows inverted values
   task automatic access(input logic w, input logic [9:0] a, input logic [7:0] d, output logic [7:0] q);
      @(negedge clk);
      req <= '{rd: !w, wr: w, addr: a, wdata: d};
      @(negedge clk);
      q = reg_rdata;
      req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
   endtask
endmodule
`default_nettype wire

// *** dv/two_level_irq_controller_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Testbench top
// ****************************************
module two_level_irq_controller_tb_top;
   import irq_ctrl_pkg::*;
   logic        clk = 1'b0;
   logic        rst_n, irq_out_pin, round_robin_done, touch_wake, coulomb_overflow, battery_overvoltage;
   logic        battery_temp_fault, clock_update_flag, alarm_match_flag, update_irq_enable, alarm_irq_enable;
   logic        battery_overcurrent, regulator_failure, power_button_n, charge_complete, usb_attach_change;
   logic        battery_presence_change, input_current_limit, input_overvoltage, die_heat_warning;
   logic        long_press_event, short_press_event, headphone_plug_change, headset_plug_change, glitch;
   logic [7:0]  reg_rdata, gpio_pin_event, q;
   logic [10:0] slow = '0;
   reg_req_s    req;
   int          err_count = 0, cmp_count = 0, seed = 81, top = 0, tmk = 'hfa;
   int          ev[6] = '{default: 0}, act[6] = '{default: 0}, mk[6] = '{0, 0, 0, 0, 3, 15};
   logic [9:0]  evo[6] = '{OFS_CONV_EVENTS, OFS_CHG_EVENTS, OFS_CLOCK_FLAGS, OFS_GPIO_EVENTS, OFS_VR_EVENTS,
                           OFS_ACC_EVENTS};
   logic [9:0]  mko[6] = '{OFS_CONV_MASK, OFS_CHG_MASK, 10'h3ff, 10'h3ff, OFS_VR_MASK, OFS_ACC_MASK};
   always #25 clk = ~clk;
   // Debounced sources only ever see glitches shorter than their debounce
   always @(negedge clk) slow <= glitch ? 11'($random(seed)) : 11'h0;
   assign power_button_n = ~slow[0];
   assign {charge_complete, usb_attach_change, battery_presence_change, input_current_limit, input_overvoltage,
           die_heat_warning, long_press_event, short_press_event, headphone_plug_change,
           headset_plug_change} = slow[10:1];
   irq_ctrl u_dut (.reg_rd(req.rd), .reg_wr(req.wr), .reg_addr(req.addr), .reg_wdata(req.wdata), .*);
   host_model u_host (.clk(clk), .reg_rdata(reg_rdata), .req(req));
   // ****************************************
   // Reference model and checking
   // ****************************************
   task automatic chk(string n, logic [7:0] seen, logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", n, exp, seen);
      end
   endtask
   function automatic bit gor(int g);
      return (g == 2) ? ev[2][7] : ((ev[g] & ~mk[g] & 'hff) != 0);
   endfunction
   task automatic upd(int g, int e, int m);
      bit o;
      o = gor(g);
      ev[g] |= e;
      mk[g] = m;
      if (!o && gor(g))
         top |= 1 << (g + 1);
   endtask
   task automatic wait_chk();
      repeat (12) @(negedge clk);
      chk("irq", irq_out_pin, (top & ~tmk & 'h7f) != 0);
   endtask
   task automatic rd(logic [9:0] a, int e, string n);
      logic [7:0] s;
      u_host.access(1'b0, a, 8'h00, s);
      chk(n, s, e[7:0]);
   endtask
   task automatic rdg(int g);
      rd(evo[g], ev[g], "group events");
      ev[g] = 0;
      upd(g, act[g], mk[g]);
   endtask
   task automatic rdt();
      repeat (4) @(negedge clk);
      rd(OFS_TOP_STATUS, top, "top status");
      top = 0;
   endtask
   task automatic wm(int g, int v);
      logic [9:0] a;
      a = (g < 0) ? OFS_TOP_MASK : mko[g];
      u_host.access(1'b1, a, v[7:0], q);
      if (g < 0)
         tmk = v;
      else
         upd(g, 0, v);
      rd(a, v, "mask");
   endtask
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (100000) @(posedge clk);
      err_count++;
      stop_test();
   end
   // ****************************************
   // Scenarios
   // ****************************************
   initial begin
      {rst_n, glitch, round_robin_done, touch_wake, coulomb_overflow, battery_overvoltage} = '0;
      {battery_temp_fault, clock_update_flag, alarm_match_flag, update_irq_enable, alarm_irq_enable} = '0;
      {battery_overcurrent, regulator_failure, gpio_pin_event} = '0;
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      glitch = 1'b1;
      rd(10'h3ff, 0, "unmapped");
      rd(OFS_TOP_MASK, tmk, "top mask");
      for (int g = 0; g < 6; g++) begin
         rd(evo[g], 0, "events");
         if (g != 2 && g != 3)
            rd(mko[g], mk[g], "mask reset");
      end
      u_host.access(1'b1, OFS_GPIO_EVENTS, 8'hff, q);
      rd(OFS_GPIO_EVENTS, 0, "event write");
      round_robin_done = 1'b1;
      upd(0, 1, 0);
      wait_chk();
      round_robin_done = 1'b0;
      wm(-1, 0);
      wait_chk();
      rdt();
      wait_chk();
      coulomb_overflow = 1'b1;
      act[0] = 4;
      upd(0, 4, 0);
      wait_chk();
      touch_wake = 1'b1;
      upd(0, 2, 0);
      wait_chk();
      rdg(0);
      wait_chk();
      coulomb_overflow = 1'b0;
      act[0] = 0;
      wait_chk();
      rdg(0);
      rdg(0);
      rdt();
      touch_wake = 1'b0;
      wm(0, 7);
      touch_wake = 1'b1;
      upd(0, 2, 7);
      wait_chk();
      wm(0, 0);
      wait_chk();
      rdg(0);
      rdt();
      for (int k = 0; k < 2; k++) begin
         {update_irq_enable, alarm_irq_enable} = k ? 2'b01 : 2'b10;
         {clock_update_flag, alarm_match_flag} = k ? 2'b10 : 2'b11;
         act[2] = k ? 'h10 : 'hb0;
         upd(2, act[2], 0);
         wait_chk();
         rdg(2);
         rdt();
         {clock_update_flag, alarm_match_flag} = 2'b00;
         act[2] = 0;
         wait_chk();
         rdg(2);
         rdg(2);
      end
      for (int d = 0; d < 10; d++) begin
         gpio_pin_event = 8'($random(seed));
         upd(3, gpio_pin_event, 0);
         repeat (d) @(negedge clk);
         u_host.access(1'b0, OFS_GPIO_EVENTS, 8'h00, q);
         wait_chk();
         rd(OFS_GPIO_EVENTS, ev[3] & ~q, "late events");
         chk("early events", q & ~ev[3], 8'h00);
         ev[3] = 0;
         rdt();
         gpio_pin_event = 8'h00;
         repeat (4) @(negedge clk);
      end
      gpio_pin_event = 8'h01;
      upd(3, 1, 0);
      wait_chk();
      rdg(3);
      rdg(3);
      rdt();
      battery_overcurrent = 1'b1;
      act[4] = 2;
      upd(4, 2, 3);
      wait_chk();
      regulator_failure = 1'b1;
      act[4] = 6;
      upd(4, 4, 3);
      wait_chk();
      {battery_overcurrent, regulator_failure} = 2'b00;
      act[4] = 0;
      wm(4, 0);
      rdg(4);
      rdg(4);
      rdt();
      for (int k = 1; k >= 0; k--) begin
         battery_overvoltage = k[0];
         upd(1, 2, 0);
         wait_chk();
         rdg(1);
         rdt();
      end
      battery_temp_fault = 1'b1;
      repeat (CYC_1MS / 2) @(negedge clk);
      battery_temp_fault = 1'b0;
      wait_chk();
      rdg(1);
      battery_temp_fault = 1'b1;
      act[1] = 4;
      repeat (CYC_1MS + 20) @(negedge clk);
      upd(1, 4, 0);
      wait_chk();
      rdt();
      battery_temp_fault = 1'b0;
      repeat (CYC_1MS + 20) @(negedge clk);
      act[1] = 0;
      wait_chk();
      glitch = 1'b0;
      for (int g = 0; g < 6; g++)
         rdg(g);
      rdt();
      stop_test();
   end
endmodule
bind irq_ctrl irq_ctrl_checker u_chk (
   .clk(clk), .rst_n(rst_n), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_rdata(reg_rdata), .gpio_pin_event(gpio_pin_event), .irq_out_pin(irq_out_pin)
);
`default_nettype wire
